// File: hdl/bdms_consts.vh
`ifndef BDMS_CONSTS_VH
`define BDMS_CONSTS_VH
// core register offsets inside every bank
`define BDMS_OFS_IND0 7'h00
`define BDMS_OFS_IND1 7'h01
`define BDMS_OFS_PCL 7'h02
`define BDMS_OFS_STAT 7'h03
`define BDMS_OFS_P0L 7'h04
`define BDMS_OFS_P0H 7'h05
`define BDMS_OFS_P1L 7'h06
`define BDMS_OFS_P1H 7'h07
`define BDMS_OFS_BANK 7'h08
`define BDMS_OFS_WACC 7'h09
`define BDMS_OFS_PROGRAM_COUNTER_UPPER_LATCH 7'h0a
`define BDMS_OFS_INTG 7'h0b
// region limits
`define BDMS_CORE_LAST 7'h0b
`define BDMS_PERI_LAST 7'h1f
`define BDMS_GRAM_LAST 7'h6f
`define BDMS_COMMON_FIRST 7'h70
// banks without peripheral windows
`define BDMS_NOPERI_B0 5'd27
`define BDMS_NOPERI_B1 5'd28
`define BDMS_NOPERI_B2 5'd29
// status bit positions
`define BDMS_ST_TO 4
`define BDMS_ST_PD 3
`define BDMS_ST_Z 2
`define BDMS_ST_DC 1
`define BDMS_ST_C 0
// reset values
`define BDMS_RST_STAT 8'h18
`define BDMS_RST_ZERO 8'h00
`define BDMS_RST_INTG 8'h01
// alu operations
`define BDMS_OP_NONE 3'd0
`define BDMS_OP_ADD 3'd1
`define BDMS_OP_SUB 3'd2
`define BDMS_OP_LOGIC 3'd3
`define BDMS_OP_RLF 3'd4
`define BDMS_OP_RRF 3'd5
`endif

// File: hdl/bdms_top.v
// How it works
// [RQ1] data memory is 32 banks of 128 bytes each
// [RQ2] 12-bit address: upper five bits bank, lower seven bits offset
// [RQ3] direct accesses take their bank from the bank_select register
// [RQ4] reads of unimplemented locations return zero
// [RQ5] memory reachable directly or through either pointer register
// [RQ6] offsets 0x00-0x0b of every bank reach the same core registers
// [RQ7] offsets 0x0c-0x1f are peripheral windows except banks 27, 28, 29
// [RQ8] up to 80 bytes general ram per bank, also reachable through pointers
// [RQ9] 16 bytes common ram shared by every bank
// [RQ10] status register accepted as destination like any register
// [RQ11] flag-updating write to status keeps computed z, dc, c instead; rotates keep the written dc, the logic op the written dc and c
// [RQ12] time-out and power-down flags ignore instruction writes
// [RQ13] status bits 7..5 read as zero
// [RQ14] time-out set by power-up, watchdog clear, sleep; cleared by timeout
// [RQ15] power-down set by power-up, watchdog clear; cleared by sleep
// [RQ16] zero flag set when result is zero, cleared otherwise
// [RQ17] digit carry set on carry out of bit 3 of add or subtract
// [RQ18] carry set on carry out of the most significant bit
// [RQ19] subtract adds two's complement; carries act as inverted borrows
// [RQ20] rotates load carry with the bit shifted out
// [RQ21] top sixteen offsets of every bank reach common ram regardless of bank
`timescale 1ns/100ps
`default_nettype none
`include "bdms_consts.vh"
module bdms_top #(
    parameter GRAM_BYTES = 80,
    parameter BANKS = 32
) (
    input wire CORE_CLK,
    input wire RST,
    input wire ACC_EN,
    input wire ACC_WE,
    input wire ACC_IND,
    input wire ACC_PSEL,
    input wire [6:0] ACC_OFS,
    input wire [7:0] ACC_WDATA,
    input wire [2:0] ALU_OP,
    input wire [7:0] ALU_A,
    input wire [7:0] ALU_B,
    input wire WDT_CLEAR,
    input wire SLEEP_EXEC,
    input wire WDT_TIMEOUT,
    input wire [7:0] PERI_RDATA,
    output reg [7:0] ACC_RDATA,
    output reg [7:0] ALU_RESULT,
    output reg PERI_EN,
    output reg PERI_WE,
    output reg [11:0] PERI_ADDR,
    output reg [7:0] PERI_WDATA,
    output reg [7:0] STATUS_OUT,
    output reg [7:0] WACC_OUT
);
////////////////////////////////////////////////////////////////////////////////
reg [7:0] stat_ff;
reg [7:0] bank_ff;
reg [7:0] wacc_ff;
reg [7:0] pcl_ff;
reg [7:0] program_counter_upper_latch_ff;
reg [7:0] intg_ff;
reg [7:0] p0l_ff;
reg [7:0] p0h_ff;
reg [7:0] p1l_ff;
reg [7:0] p1h_ff;
reg [7:0] gram [0:BANKS*GRAM_BYTES-1];
reg [7:0] common [0:15];
reg [7:0] nxt_stat;
reg [7:0] alu_res;
reg alu_c;
reg alu_dc;
reg [9:0] sum;
reg [11:0] ea;
reg [6:0] ofs;
reg [4:0] bank;
reg [11:0] gidx;
reg [7:0] rd;
wire [15:0] ptr;
wire alu_flags;
reg [7:0] nxt_pcl;
reg [7:0] nxt_program_counter_upper_latch;
reg [7:0] nxt_intg;
reg [7:0] nxt_p0l;
reg [7:0] nxt_p0h;
reg [7:0] nxt_p1l;
reg [7:0] nxt_p1h;
reg [7:0] nxt_bank;
reg [7:0] nxt_wacc;
wire acc_wr;
wire peri_acc;
wire gram_we;
wire common_we;

localparam [11:0] GRAM_W = GRAM_BYTES[11:0];
////////////////////////////////////////////////////////////////////////////////
// true for offsets of a bank that hold general ram
function gram_hit;
    input [6:0] o;
    begin
        gram_hit = (o > `BDMS_PERI_LAST) && (o <= `BDMS_GRAM_LAST);
    end
endfunction

// true for offsets of a bank that reach a peripheral window
function peri_hit;
    input [6:0] o;
    input [4:0] b;
    begin
        peri_hit = (o > `BDMS_CORE_LAST) && (o <= `BDMS_PERI_LAST) &&
            (b != `BDMS_NOPERI_B0) && (b != `BDMS_NOPERI_B1) && (b != `BDMS_NOPERI_B2);
    end
endfunction

// true for the shared top offsets of every bank
function common_hit;
    input [6:0] o;
    begin
        common_hit = (o >= `BDMS_COMMON_FIRST);
    end
endfunction

// true for alu codes that produce a result and flags
function alu_known;
    input [2:0] p;
    begin
        alu_known = (p == `BDMS_OP_ADD) || (p == `BDMS_OP_SUB) || (p == `BDMS_OP_LOGIC) ||
            (p == `BDMS_OP_RLF) || (p == `BDMS_OP_RRF);
    end
endfunction

// eight-bit add with carry in, gives {carry, digit carry, sum}
function [9:0] add8;
    input [7:0] x;
    input [7:0] y;
    input cin;
    reg [8:0] s;
    reg [4:0] n;
    begin
        s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
        n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        add8 = {s[8], n[4], s[7:0]};
    end
endfunction
////////////////////////////////////////////////////////////////////////////////
// effective address
assign ptr = ACC_PSEL ? {p1h_ff, p1l_ff} : {p0h_ff, p0l_ff};
always @* begin
    if (ACC_IND) begin
        ea = ptr[11:0]; // [RQ5]
    end else begin
        ea = {bank_ff[4:0], ACC_OFS}; // [RQ3]
    end
    bank = ea[11:7]; // [RQ2] [RQ1]
    ofs = ea[6:0];
    gidx = {7'h00, bank} * GRAM_W + {5'h00, ofs} - 12'h020; // [RQ8]
end

assign acc_wr = ACC_EN && ACC_WE;
assign peri_acc = ACC_EN && peri_hit(ofs, bank); // [RQ7]
assign gram_we = acc_wr && gram_hit(ofs);
assign common_we = acc_wr && common_hit(ofs);
////////////////////////////////////////////////////////////////////////////////
// alu and flags
always @* begin
    alu_res = 8'h00;
    alu_c = stat_ff[`BDMS_ST_C];
    alu_dc = stat_ff[`BDMS_ST_DC];
    sum = 10'h000;
    case (ALU_OP)
        `BDMS_OP_ADD: begin
            sum = add8(ALU_A, ALU_B, 1'b0);
            alu_res = sum[7:0];
            alu_c = sum[9]; // [RQ18]
            alu_dc = sum[8]; // [RQ17]
        end
        `BDMS_OP_SUB: begin
            sum = add8(ALU_A, ~ALU_B, 1'b1); // [RQ19]
            alu_res = sum[7:0];
            alu_c = sum[9];
            alu_dc = sum[8];
        end
        `BDMS_OP_LOGIC: begin
            alu_res = ALU_A;
        end
        `BDMS_OP_RLF: begin
            alu_res = {ALU_A[6:0], stat_ff[`BDMS_ST_C]};
            alu_c = ALU_A[7]; // [RQ20]
        end
        `BDMS_OP_RRF: begin
            alu_res = {stat_ff[`BDMS_ST_C], ALU_A[7:1]};
            alu_c = ALU_A[0]; // [RQ20]
        end
        default: begin
            alu_res = 8'h00;
        end
    endcase
end
assign alu_flags = alu_known(ALU_OP);
always @* begin
    nxt_stat = stat_ff;
    if (ACC_EN && ACC_WE && ofs == `BDMS_OFS_STAT) begin
        nxt_stat[2:0] = ACC_WDATA[2:0]; // [RQ10]
    end
    if (alu_flags) begin
        nxt_stat[`BDMS_ST_Z] = (alu_res == 8'h00); // [RQ16] [RQ11]
        if (ALU_OP != `BDMS_OP_LOGIC) begin
            nxt_stat[`BDMS_ST_C] = alu_c; // [RQ11]
        end
        if (ALU_OP == `BDMS_OP_ADD || ALU_OP == `BDMS_OP_SUB) begin
            nxt_stat[`BDMS_ST_DC] = alu_dc;
        end
    end
    if (WDT_CLEAR) begin
        nxt_stat[`BDMS_ST_TO] = 1'b1; // [RQ14]
        nxt_stat[`BDMS_ST_PD] = 1'b1; // [RQ15]
    end else if (SLEEP_EXEC) begin
        nxt_stat[`BDMS_ST_TO] = 1'b1; // [RQ14]
        nxt_stat[`BDMS_ST_PD] = 1'b0; // [RQ15]
    end
    if (WDT_TIMEOUT) begin
        nxt_stat[`BDMS_ST_TO] = 1'b0; // [RQ14]
    end
    nxt_stat[7:5] = 3'b000; // [RQ13] [RQ12]
end
////////////////////////////////////////////////////////////////////////////////
// read decode
always @* begin
    rd = 8'h00; // [RQ4]
    if (ofs <= `BDMS_CORE_LAST) begin
        if (ofs == `BDMS_OFS_PCL) begin // [RQ6]
            rd = pcl_ff;
        end else if (ofs == `BDMS_OFS_STAT) begin
            rd = stat_ff;
        end else if (ofs == `BDMS_OFS_P0L) begin
            rd = p0l_ff;
        end else if (ofs == `BDMS_OFS_P0H) begin
            rd = p0h_ff;
        end else if (ofs == `BDMS_OFS_P1L) begin
            rd = p1l_ff;
        end else if (ofs == `BDMS_OFS_P1H) begin
            rd = p1h_ff;
        end else if (ofs == `BDMS_OFS_BANK) begin
            rd = bank_ff;
        end else if (ofs == `BDMS_OFS_WACC) begin
            rd = wacc_ff;
        end else if (ofs == `BDMS_OFS_PROGRAM_COUNTER_UPPER_LATCH) begin
            rd = program_counter_upper_latch_ff;
        end else if (ofs == `BDMS_OFS_INTG) begin
            rd = intg_ff;
        end
    end else if (ofs <= `BDMS_PERI_LAST) begin
        if (peri_hit(ofs, bank)) begin
            rd = PERI_RDATA; // [RQ7]
        end
    end else if (gram_hit(ofs)) begin
        rd = gram[gidx]; // [RQ8]
    end else begin
        rd = common[ofs[3:0]]; // [RQ9] [RQ21]
    end
end
////////////////////////////////////////////////////////////////////////////////
// storage
always @(posedge CORE_CLK) begin
    if (gram_we) begin
        gram[gidx] <= ACC_WDATA; // [RQ8]
    end
end

// common ram ignores the bank number
always @(posedge CORE_CLK) begin
    if (common_we) begin
        common[ofs[3:0]] <= ACC_WDATA; // [RQ9] [RQ21]
    end
end

////////////////////////////////////////////////////////////////////////////////
// core register writes, the same in every bank
always @* begin
    nxt_pcl = pcl_ff;
    nxt_program_counter_upper_latch = program_counter_upper_latch_ff;
    nxt_intg = intg_ff;
    nxt_p0l = p0l_ff;
    nxt_p0h = p0h_ff;
    nxt_p1l = p1l_ff;
    nxt_p1h = p1h_ff;
    nxt_bank = bank_ff;
    nxt_wacc = wacc_ff;
    if (acc_wr) begin
        if (ofs == `BDMS_OFS_PCL) begin // [RQ6]
            nxt_pcl = ACC_WDATA;
        end else if (ofs == `BDMS_OFS_P0L) begin
            nxt_p0l = ACC_WDATA;
        end else if (ofs == `BDMS_OFS_P0H) begin
            nxt_p0h = ACC_WDATA;
        end else if (ofs == `BDMS_OFS_P1L) begin
            nxt_p1l = ACC_WDATA;
        end else if (ofs == `BDMS_OFS_P1H) begin
            nxt_p1h = ACC_WDATA;
        end else if (ofs == `BDMS_OFS_BANK) begin
            nxt_bank = {3'b000, ACC_WDATA[4:0]}; // [RQ3]
        end else if (ofs == `BDMS_OFS_WACC) begin
            nxt_wacc = ACC_WDATA;
        end else if (ofs == `BDMS_OFS_PROGRAM_COUNTER_UPPER_LATCH) begin
            nxt_program_counter_upper_latch = {1'b0, ACC_WDATA[6:0]};
        end else if (ofs == `BDMS_OFS_INTG) begin
            nxt_intg = {ACC_WDATA[7:6], 5'b00000, ACC_WDATA[0]};
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// status register
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        stat_ff <= `BDMS_RST_STAT; // [RQ14] [RQ15]
    end else begin
        stat_ff <= nxt_stat;
    end
end

////////////////////////////////////////////////////////////////////////////////
// core registers
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        bank_ff <= `BDMS_RST_ZERO;
        wacc_ff <= `BDMS_RST_ZERO;
        pcl_ff <= `BDMS_RST_ZERO;
        program_counter_upper_latch_ff <= `BDMS_RST_ZERO;
        intg_ff <= `BDMS_RST_INTG;
        p0l_ff <= `BDMS_RST_ZERO;
        p0h_ff <= `BDMS_RST_ZERO;
        p1l_ff <= `BDMS_RST_ZERO;
        p1h_ff <= `BDMS_RST_ZERO;
    end else begin
        bank_ff <= nxt_bank;
        wacc_ff <= nxt_wacc;
        pcl_ff <= nxt_pcl;
        program_counter_upper_latch_ff <= nxt_program_counter_upper_latch;
        intg_ff <= nxt_intg;
        p0l_ff <= nxt_p0l;
        p0h_ff <= nxt_p0h;
        p1l_ff <= nxt_p1l;
        p1h_ff <= nxt_p1h;
    end
end

////////////////////////////////////////////////////////////////////////////////
// registered outputs
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        ACC_RDATA <= 8'h00;
        ALU_RESULT <= 8'h00;
        PERI_EN <= 1'b0;
        PERI_WE <= 1'b0;
        PERI_ADDR <= 12'h000;
        PERI_WDATA <= 8'h00;
        STATUS_OUT <= `BDMS_RST_STAT;
        WACC_OUT <= 8'h00;
    end else begin
        STATUS_OUT <= nxt_stat;
        ALU_RESULT <= alu_res;
        ACC_RDATA <= ACC_EN ? rd : 8'h00;
        PERI_EN <= peri_acc; // [RQ7]
        PERI_WE <= peri_acc && ACC_WE; // [RQ7]
        PERI_ADDR <= ea;
        PERI_WDATA <= ACC_WDATA;
        WACC_OUT <= nxt_wacc;
    end
end

endmodule // bdms_top
`default_nettype wire

// File: tb/bdms_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module bdms_chk (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic ACC_EN,
    input wire logic ACC_WE,
    input wire logic ACC_IND,
    input wire logic [6:0] ACC_OFS,
    input wire logic [7:0] ACC_WDATA,
    input wire logic [2:0] ALU_OP,
    input wire logic [7:0] ALU_A,
    input wire logic [7:0] ALU_B,
    input wire logic WDT_CLEAR,
    input wire logic SLEEP_EXEC,
    input wire logic WDT_TIMEOUT,
    input wire logic [7:0] ALU_RESULT,
    input wire logic PERI_EN,
    input wire logic [11:0] PERI_ADDR,
    input wire logic [7:0] STATUS_OUT
);
    logic [8:0] s9;
    logic [4:0] s5;
    logic [7:0] bb, er;
    logic [2:0] ef;
    logic ci;
    wire dir = ACC_EN && !ACC_IND;
    wire sw = dir && ACC_WE && ACC_OFS == 7'h03;
    // expected result and {z, dc, c} of this cycle's alu request
    always_comb begin
        ci = ALU_OP == 3'd2;
        bb = ci ? ~ALU_B : ALU_B;
        s9 = {1'b0, ALU_A} + {1'b0, bb} + {8'h00, ci};
        s5 = {1'b0, ALU_A[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        er = s9[7:0];
        ef = {er == 8'h00, s5[4], s9[8]};
        if (ALU_OP == 3'd4) begin
            er = {ALU_A[6:0], STATUS_OUT[0]};
            ef = {er == 8'h00, STATUS_OUT[1], ALU_A[7]};
        end
        if (ALU_OP == 3'd5) begin
            er = {STATUS_OUT[0], ALU_A[7:1]};
            ef = {er == 8'h00, STATUS_OUT[1], ALU_A[0]};
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    chk_upper_zero: assert property (STATUS_OUT[7:5] == 3'b000)
        else $error("status upper bits set");
    chk_arith_flags: assert property ((ALU_OP == 3'd1 || ALU_OP == 3'd2) |=>
        ALU_RESULT == $past(er) && STATUS_OUT[2:0] == $past(ef)) else $error("arith flags");
    chk_rotate_carry: assert property ((ALU_OP == 3'd4 || ALU_OP == 3'd5) && !sw |=>
        ALU_RESULT == $past(er) && STATUS_OUT[2:0] == $past(ef)) else $error("rotate carry");
    chk_logic_zero: assert property (ALU_OP == 3'd3 |=>
        STATUS_OUT[2] == ($past(ALU_A) == 8'h00)) else $error("logic zero");
    chk_flag_write: assert property (sw && ALU_OP == 3'd0 |=>
        {5'h00, STATUS_OUT[2:0]} == ($past(ACC_WDATA) & 8'h07)) else $error("flag write");
    chk_tp_locked: assert property (sw && !(WDT_CLEAR || SLEEP_EXEC || WDT_TIMEOUT) |=>
        $stable(STATUS_OUT[4:3])) else $error("reset flags written");
    chk_timeout_clr: assert property (WDT_TIMEOUT |=> !STATUS_OUT[4])
        else $error("timeout flag");
    chk_sleep_flags: assert property (SLEEP_EXEC && !WDT_TIMEOUT && !WDT_CLEAR |=>
        STATUS_OUT[4:3] == 2'b10) else $error("sleep flags");
    chk_wdt_clear: assert property (WDT_CLEAR && !WDT_TIMEOUT && !SLEEP_EXEC |=>
        STATUS_OUT[4:3] == 2'b11) else $error("clear flags");
    chk_peri_offset: assert property (dir && ACC_OFS >= 7'h0c && ACC_OFS <= 7'h1f |=>
        !PERI_EN || PERI_ADDR[6:0] == $past(ACC_OFS)) else $error("peri offset");
endmodule // bdms_chk
bind bdms_top bdms_chk u_chk (.CORE_CLK(CORE_CLK), .RST(RST), .ACC_EN(ACC_EN), .ACC_WE(ACC_WE),
    .ACC_IND(ACC_IND), .ACC_OFS(ACC_OFS), .ACC_WDATA(ACC_WDATA), .ALU_OP(ALU_OP), .ALU_A(ALU_A),
    .ALU_B(ALU_B), .WDT_CLEAR(WDT_CLEAR), .SLEEP_EXEC(SLEEP_EXEC), .WDT_TIMEOUT(WDT_TIMEOUT),
    .ALU_RESULT(ALU_RESULT), .PERI_EN(PERI_EN), .PERI_ADDR(PERI_ADDR), .STATUS_OUT(STATUS_OUT));
`default_nettype wire

// File: tb/bdms_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module bdms_core_model (
    input wire logic clk,
    output logic en,
    output logic we,
    output logic ind,
    output logic psel,
    output logic [6:0] ofs,
    output logic [7:0] wd,
    output logic [2:0] op,
    output logic [7:0] a,
    output logic [7:0] b
);
    initial {en, we, ind, psel, ofs, wd, op, a, b} = '0;
    // one request, held through the taking edge; idle write data flips, ofs and operands hold
    task automatic issue(input logic [3:0] c, input logic [6:0] o, input logic [7:0] d,
        input logic [2:0] p, input logic [7:0] x, input logic [7:0] y);
        @(posedge clk);
        {en, we, ind, psel} <= c;
        ofs <= o;
        wd <= d;
        op <= p;
        a <= x;
        b <= y;
        @(posedge clk);
        {en, we, op} <= '0;
        wd <= ~d;
    endtask
endmodule // bdms_core_model
`default_nettype wire

// File: tb/bdms_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module bdms_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wclr = 1'b0, slp = 1'b0, wto = 1'b0;
    logic en, we, ind, psel, pen, pwe;
    logic [7:0] pwdat;
    logic [6:0] ofs;
    logic [7:0] wd, a, b, rdat, res, st, wacc;
    logic [2:0] op;
    logic [11:0] padr;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    bdms_core_model core (.clk(clk), .en(en), .we(we), .ind(ind), .psel(psel), .ofs(ofs),
        .wd(wd), .op(op), .a(a), .b(b));
    bdms_top dut (.CORE_CLK(clk), .RST(rst), .ACC_EN(en), .ACC_WE(we), .ACC_IND(ind),
        .ACC_PSEL(psel), .ACC_OFS(ofs), .ACC_WDATA(wd), .ALU_OP(op), .ALU_A(a), .ALU_B(b),
        .WDT_CLEAR(wclr), .SLEEP_EXEC(slp), .WDT_TIMEOUT(wto), .PERI_RDATA(8'h5a),
        .ACC_RDATA(rdat), .ALU_RESULT(res), .PERI_EN(pen), .PERI_WE(pwe), .PERI_ADDR(padr),
        .PERI_WDATA(pwdat), .STATUS_OUT(st), .WACC_OUT(wacc));
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic [3:0] c, input logic [6:0] o, input logic [7:0] d);
        core.issue(c, o, d, 3'd0, 8'h00, 8'h00);
        #1;
    endtask
    task automatic pulse(input logic [2:0] v);
        @(posedge clk);
        {wclr, slp, wto} <= v;
        @(posedge clk);
        {wclr, slp, wto} <= 3'b000;
        #1;
    endtask
    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        chk("status", 12'h018, st);
        acc(4'b1000, 7'h03, 8'h00);
        chk("rd_status", 12'h018, rdat);
        $display("test reset done");
    endtask
    task automatic t_banks;
        acc(4'b1100, 7'h08, 8'h05);
        acc(4'b1100, 7'h20, 8'ha5);
        acc(4'b1100, 7'h08, 8'h06);
        acc(4'b1100, 7'h20, 8'h3c);
        acc(4'b1100, 7'h70, 8'h77);
        acc(4'b1100, 7'h09, 8'h4b);
        chk("wacc", 12'h04b, wacc);
        acc(4'b1000, 7'h08, 8'h00);
        chk("bank", 12'h006, rdat);
        acc(4'b1100, 7'h04, 8'ha0);
        acc(4'b1100, 7'h05, 8'h02);
        acc(4'b1010, 7'h00, 8'h00);
        chk("ind0_rd", 12'h0a5, rdat);
        acc(4'b1100, 7'h06, 8'ha1);
        acc(4'b1100, 7'h07, 8'h02);
        acc(4'b1111, 7'h00, 8'h99);
        acc(4'b1000, 7'h20, 8'h00);
        chk("gram6", 12'h03c, rdat);
        acc(4'b1100, 7'h08, 8'h05);
        acc(4'b1000, 7'h70, 8'h00);
        chk("common", 12'h077, rdat);
        acc(4'b1000, 7'h21, 8'h00);
        chk("ind1_wr", 12'h099, rdat);
        acc(4'b1000, 7'h01, 8'h00);
        chk("ind_port", 12'h000, rdat);
        acc(4'b1000, 7'h0c, 8'h00);
        chk("peri_rd", 12'h05a, rdat);
        chk("peri_adr", 12'h28c, padr);
        chk("peri_en", 12'h001, pen);
        acc(4'b1100, 7'h08, 8'h1b);
        acc(4'b1000, 7'h0c, 8'h00);
        chk("b27_rd", 12'h000, rdat);
        chk("b27_en", 12'h000, pen);
        acc(4'b1100, 7'h0d, 8'h3e);
        chk("b27_we", 12'h000, pwe);
        acc(4'b1100, 7'h08, 8'h05);
        acc(4'b1100, 7'h0d, 8'hc3);
        chk("peri_we", 12'h001, pwe);
        chk("peri_wd", 12'h0c3, pwdat);
        chk("peri_wadr", 12'h28d, padr);
        $display("test banks done");
    endtask
    task automatic t_alu;
        logic [29:0] tv [7] = '{{3'd1, 8'h0f, 8'h01, 8'h10, 3'b010},
            {3'd1, 8'hff, 8'h01, 8'h00, 3'b111}, {3'd2, 8'h05, 8'h05, 8'h00, 3'b111},
            {3'd2, 8'h00, 8'h01, 8'hff, 3'b000}, {3'd4, 8'h81, 8'h00, 8'h02, 3'b001},
            {3'd5, 8'h02, 8'h00, 8'h81, 3'b000}, {3'd3, 8'h00, 8'h00, 8'h00, 3'b100}};
        for (int i = 0; i < 7; i++) begin
            core.issue(4'b0000, 7'h00, 8'h00, tv[i][29:27], tv[i][26:19], tv[i][18:11]);
            #1;
            chk("alu_res", tv[i][10:3], res);
            chk("alu_flags", tv[i][2:0], st[2:0]);
        end
        core.issue(4'b1100, 7'h03, 8'hff, 3'd1, 8'h01, 8'h01);
        #1;
        chk("st_override", 12'h018, st);
        acc(4'b1100, 7'h03, 8'hff);
        chk("st_write", 12'h01f, st);
        acc(4'b1100, 7'h03, 8'h00);
        chk("st_clear", 12'h018, st);
        $display("test alu done");
    endtask
    task automatic t_wdt;
        pulse(3'b001);
        chk("timeout", 12'h008, st);
        pulse(3'b010);
        chk("sleep", 12'h010, st);
        pulse(3'b100);
        chk("wdt_clear", 12'h018, st);
        $display("test wdt done");
    endtask
    ////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            results();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_banks();
        t_alu();
        t_wdt();
        results();
    end
endmodule // bdms_top_tb
`default_nettype wire
